// File: src/itb_pkg.sv
// constants for the interrupt controller and time base
package itb_pkg;
    // register index on the special-function register port
    localparam logic [2:0] IDX_EDGE = 3'h0;
    localparam logic [2:0] IDX_CTRL0 = 3'h1;
    localparam logic [2:0] IDX_CTRL1 = 3'h2;
    localparam logic [2:0] IDX_PSC = 3'h3;
    localparam logic [2:0] IDX_TICK = 3'h4;
    // source numbering, also the fixed priority (0 wins)
    localparam int SRC_PIN0 = 0;
    localparam int SRC_TICK = 1;
    localparam int SRC_TIMER = 2;
    localparam int SRC_CONV = 3;
    localparam int SRC_PIN1 = 4;
    localparam int NSRC = 5;
    // first control register field positions
    localparam int C0_EMI = 0;
    localparam int C0_PIN0_EN = 1;
    localparam int C0_TICK_EN = 2;
    localparam int C0_TIMER_EN = 3;
    localparam int C0_PIN0_F = 4;
    localparam int C0_TICK_F = 5;
    localparam int C0_TIMER_F = 6;
    // second control register field positions
    localparam int C1_CONV_EN = 0;
    localparam int C1_PIN1_EN = 1;
    localparam int C1_CONV_F = 4;
    localparam int C1_PIN1_F = 5;
    // prescaler and tick register fields
    localparam int PSC_ON = 2;
    localparam int TICK_RUN = 7;
    localparam logic [1:0] SRC_SYS = 2'h0;
    localparam logic [1:0] SRC_SYS4 = 2'h1;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    // edge-select encodings
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // tick period is TICK_MIN_PERIOD shifted left by sel, 2^(4+sel) prescaled clocks
    localparam logic [11:0] TICK_MIN_PERIOD = 12'h010;
    localparam int TICK_CNT_W = 11;
    localparam logic [7:0] REG_RESET = 8'h00;
endpackage

// File: src/itb_ctrl.sv
// interrupt controller with prescaler and periodic time-base tick
module itb_ctrl #(
    parameter bit TWO_PINS = 1'b1,
    parameter int PC_W = 11,
    parameter logic [PC_W-1:0] VEC_PIN0 = 'h004,
    parameter logic [PC_W-1:0] VEC_TICK = 'h008,
    parameter logic [PC_W-1:0] VEC_TIMER = 'h00C,
    parameter logic [PC_W-1:0] VEC_CONV = 'h010,
    parameter logic [PC_W-1:0] VEC_PIN1 = 'h014
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [2:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic [1:0] ext_irq_pin,
    input wire logic sub_clk,
    input wire logic timer_ovf,
    input wire logic conv_done,
    input wire logic cpu_boundary,
    input wire logic [PC_W-1:0] cpu_next_pc,
    input wire logic stack_full,
    input wire logic reti_exec,
    input wire logic ret_exec,
    output logic irq_pending,
    output logic irq_take,
    output logic stack_push,
    output logic [PC_W-1:0] stack_push_pc,
    output logic pc_load,
    output logic [PC_W-1:0] pc_load_addr,
    output logic stack_pop,
    output logic wake
);
    typedef struct packed {
        logic [3:0] edge_sel;
        logic global_irq_enable;
        logic [4:0] en;
        logic [4:0] flag;
        logic psc_on;
        logic [1:0] psc_src;
        logic tick_run;
        logic [2:0] tick_sel;
        logic [1:0] div4;
        logic [10:0] tick_cnt;
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic [1:0] pin_d;
        logic sub_s1;
        logic sub_s2;
        logic sub_d;
        logic push;
        logic [PC_W-1:0] push_pc;
        logic load;
        logic [PC_W-1:0] vec;
        logic pop;
        logic wake;
        logic [7:0] rdata;
    } itb_state_t;

    itb_state_t st;
    itb_state_t next_st;

    // sources that do not exist in the one-pin variant stay at zero
    localparam logic [4:0] SRC_MASK = TWO_PINS ? 5'h1F : 5'h0F;

    function automatic logic edge_hit(input logic [1:0] sel, input logic now,
                                      input logic prev);
        logic r;
        r = 1'b0;
        unique case (sel)
            itb_pkg::EDGE_OFF: r = 1'b0;
            itb_pkg::EDGE_RISE: r = now & ~prev;
            itb_pkg::EDGE_FALL: r = ~now & prev;
            itb_pkg::EDGE_BOTH: r = now ^ prev;
        endcase
        return r;
    endfunction

    function automatic logic [10:0] tick_last(input logic [2:0] sel);
        logic [11:0] p;
        p = itb_pkg::TICK_MIN_PERIOD << sel;
        return 11'(p - 12'h001);
    endfunction

    // lowest index wins
    function automatic logic [2:0] pick(input logic [4:0] req);
        logic [2:0] r;
        r = 3'h0;
        for (int i = itb_pkg::NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [PC_W-1:0] vec_of(input logic [2:0] idx);
        logic [PC_W-1:0] v;
        v = VEC_PIN0;
        unique case (idx)
            3'h0: v = VEC_PIN0;
            3'h1: v = VEC_TICK;
            3'h2: v = VEC_TIMER;
            3'h3: v = VEC_CONV;
            default: v = VEC_PIN1;
        endcase
        return v;
    endfunction

    logic [4:0] armed;
    logic [2:0] win;
    logic take;
    logic psc_tick;
    logic tick_ovf;
    logic [4:0] hw_set;
    logic [4:0] svc_clr;
    logic wr0;
    logic wr1;

    assign armed = st.flag & st.en & SRC_MASK;
    assign win = pick(armed);
    assign irq_pending = st.global_irq_enable & (|armed);
    assign take = ce & cpu_boundary & irq_pending & ~stack_full;
    assign irq_take = take;
    assign wr0 = sfr_wr & (sfr_addr == itb_pkg::IDX_CTRL0);
    assign wr1 = sfr_wr & (sfr_addr == itb_pkg::IDX_CTRL1);

    always_comb begin
        unique case (st.psc_src)
            itb_pkg::SRC_SYS: psc_tick = st.psc_on;
            itb_pkg::SRC_SYS4: psc_tick = st.psc_on & (st.div4 == itb_pkg::DIV4_LAST);
            default: psc_tick = st.psc_on & st.sub_s2 & ~st.sub_d;
        endcase
    end

    assign tick_ovf = st.tick_run & psc_tick & (st.tick_cnt == tick_last(st.tick_sel));

    always_comb begin
        hw_set = 5'h00;
        hw_set[itb_pkg::SRC_PIN0] = edge_hit(st.edge_sel[1:0], st.pin_s2[0], st.pin_d[0]);
        hw_set[itb_pkg::SRC_PIN1] = edge_hit(st.edge_sel[3:2], st.pin_s2[1], st.pin_d[1]);
        hw_set[itb_pkg::SRC_TICK] = tick_ovf;
        hw_set[itb_pkg::SRC_TIMER] = timer_ovf;
        hw_set[itb_pkg::SRC_CONV] = conv_done;
        hw_set = hw_set & SRC_MASK;
        svc_clr = 5'h00;
        if (take) begin
            svc_clr[win] = 1'b1;
        end
    end

    always_comb begin
        logic [4:0] f;
        f = st.flag;
        next_st = st;
        // pin sampling: first stage is read only by the second
        // sync flops reset low; the select resets to off, so no false edge follows reset
        next_st.pin_s1 = ext_irq_pin;
        next_st.pin_s2 = st.pin_s1;
        next_st.pin_d = st.pin_s2;
        next_st.sub_s1 = sub_clk;
        next_st.sub_s2 = st.sub_s1;
        next_st.sub_d = st.sub_s2;
        // prescaler divider clears to zero and stops with the enable to save power
        if (st.psc_on) begin
            next_st.div4 = st.div4 + 2'h1;
        end else begin
            next_st.div4 = 2'h0;
        end
        if (!st.tick_run) begin
            next_st.tick_cnt = '0;
        end else if (psc_tick) begin
            next_st.tick_cnt = tick_ovf ? '0 : st.tick_cnt + 11'h001;
        end
        // register writes
        if (sfr_wr) begin
            unique case (sfr_addr)
                itb_pkg::IDX_EDGE: begin
                    next_st.edge_sel = TWO_PINS ? sfr_wdata[3:0] : {2'h0, sfr_wdata[1:0]};
                end
                itb_pkg::IDX_CTRL0: begin
                    next_st.global_irq_enable = sfr_wdata[itb_pkg::C0_EMI];
                    next_st.en[itb_pkg::SRC_PIN0] = sfr_wdata[itb_pkg::C0_PIN0_EN];
                    next_st.en[itb_pkg::SRC_TICK] = sfr_wdata[itb_pkg::C0_TICK_EN];
                    next_st.en[itb_pkg::SRC_TIMER] = sfr_wdata[itb_pkg::C0_TIMER_EN];
                end
                itb_pkg::IDX_CTRL1: begin
                    next_st.en[itb_pkg::SRC_CONV] = sfr_wdata[itb_pkg::C1_CONV_EN];
                    next_st.en[itb_pkg::SRC_PIN1] = TWO_PINS & sfr_wdata[itb_pkg::C1_PIN1_EN];
                end
                itb_pkg::IDX_PSC: begin
                    next_st.psc_on = sfr_wdata[itb_pkg::PSC_ON];
                    next_st.psc_src = sfr_wdata[1:0];
                end
                itb_pkg::IDX_TICK: begin
                    next_st.tick_run = sfr_wdata[itb_pkg::TICK_RUN];
                    next_st.tick_sel = sfr_wdata[2:0];
                end
                default: begin
                end
            endcase
        end
        if (wr0) begin
            f[itb_pkg::SRC_PIN0] = sfr_wdata[itb_pkg::C0_PIN0_F];
            f[itb_pkg::SRC_TICK] = sfr_wdata[itb_pkg::C0_TICK_F];
            f[itb_pkg::SRC_TIMER] = sfr_wdata[itb_pkg::C0_TIMER_F];
        end
        if (wr1) begin
            f[itb_pkg::SRC_CONV] = sfr_wdata[itb_pkg::C1_CONV_F];
            f[itb_pkg::SRC_PIN1] = sfr_wdata[itb_pkg::C1_PIN1_F];
        end
        // a new event beats a same-cycle clear from software or service
        next_st.flag = ((f & ~svc_clr) | hw_set) & SRC_MASK;
        next_st.wake = |(next_st.flag & ~st.flag);
        // return from interrupt
        next_st.pop = reti_exec | ret_exec;
        if (reti_exec) begin
            next_st.global_irq_enable = 1'b1;
        end
        next_st.push = take;
        next_st.load = take;
        if (take) begin
            next_st.global_irq_enable = 1'b0;
            next_st.push_pc = cpu_next_pc;
            next_st.vec = vec_of(win);
        end
        // registered read, one cycle behind the address
        unique case (sfr_addr)
            itb_pkg::IDX_EDGE: next_st.rdata = {4'h0, st.edge_sel};
            itb_pkg::IDX_CTRL0: next_st.rdata = {1'b0, st.flag[itb_pkg::SRC_TIMER],
                st.flag[itb_pkg::SRC_TICK], st.flag[itb_pkg::SRC_PIN0],
                st.en[itb_pkg::SRC_TIMER], st.en[itb_pkg::SRC_TICK],
                st.en[itb_pkg::SRC_PIN0], st.global_irq_enable};
            itb_pkg::IDX_CTRL1: next_st.rdata = {2'h0, st.flag[itb_pkg::SRC_PIN1],
                st.flag[itb_pkg::SRC_CONV], 2'h0, st.en[itb_pkg::SRC_PIN1],
                st.en[itb_pkg::SRC_CONV]};
            itb_pkg::IDX_PSC: next_st.rdata = {5'h00, st.psc_on, st.psc_src};
            itb_pkg::IDX_TICK: next_st.rdata = {st.tick_run, 4'h0, st.tick_sel};
            default: next_st.rdata = itb_pkg::REG_RESET;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign sfr_rdata = st.rdata;
    assign stack_push = st.push;
    assign stack_push_pc = st.push_pc;
    assign pc_load = st.load;
    assign pc_load_addr = st.vec;
    assign stack_pop = st.pop;
    assign wake = st.wake;

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence s_take;
        take;
    endsequence
    sequence s_vectored;
        st.push && st.load && !st.global_irq_enable;
    endsequence
    property p_vector;
        s_take |=> s_vectored;
    endproperty

    AST_TAKE_VECTOR: assert property (p_vector)
        else $error("taken interrupt did not push and load");
    AST_TAKE_PC: assert property (take |=> st.push_pc == $past(cpu_next_pc))
        else $error("pushed pc differs from next pc");
    AST_STACK_FULL: assert property (stack_full |-> !irq_take)
        else $error("acknowledged with full stack");
    AST_GLOBAL_OFF: assert property (!st.global_irq_enable |-> !irq_pending)
        else $error("pending without global enable");
    AST_PRIO_PIN0: assert property (take && armed[0] |=> st.vec == VEC_PIN0)
        else $error("pin0 lost priority");
    AST_RETI: assert property (ce && reti_exec && !take |=> st.global_irq_enable && st.pop)
        else $error("return did not restore global enable");
    AST_TIMER_SET: assert property (ce && timer_ovf |=> st.flag[itb_pkg::SRC_TIMER])
        else $error("timer overflow lost");
    AST_CONV_SET: assert property (ce && conv_done ##0 !st.global_irq_enable |=> st.flag[3])
        else $error("conversion request lost while blocked");
    AST_WAKE: assert property (ce && timer_ovf && !st.flag[2] |=> st.wake)
        else $error("no wake on flag rise");
    AST_HOLD: assert property (ce && st.flag[2] && !wr0 && !(take && win == 3'h2)
        |=> st.flag[2])
        else $error("timer flag dropped by itself");
    AST_TICK_IDLE: assert property (ce && !st.tick_run |=> st.tick_cnt == '0)
        else $error("tick counter ran while stopped");
    AST_TICK_WRAP: assert property (ce && tick_ovf |=> st.flag[1] && st.tick_cnt == '0)
        else $error("tick overflow did not set flag and restart");
    AST_TIMER_CLR: assert property (take && win == 3'h2 && !timer_ovf |=> !st.flag[2])
        else $error("serviced timer flag not cleared");
    AST_CONV_CLR: assert property (take && win == 3'h3 && !conv_done
        |=> !st.flag[3] && !st.global_irq_enable)
        else $error("serviced conversion flag or global enable not cleared");
    AST_RET_KEEP: assert property (ce && ret_exec && !reti_exec && !take && !wr0
        |=> st.pop && st.global_irq_enable == $past(st.global_irq_enable))
        else $error("plain return changed the global enable");

    sequence s_pin0_rise;
        ce && st.edge_sel[1:0] == itb_pkg::EDGE_RISE && st.pin_s2[0] && !st.pin_d[0];
    endsequence
    property p_pin0_rise;
        s_pin0_rise |=> st.flag[itb_pkg::SRC_PIN0];
    endproperty
    AST_PIN0_RISE: assert property (p_pin0_rise)
        else $error("rising edge on pin 0 not flagged");
    AST_PIN0_FALL: assert property (ce && st.edge_sel[1:0] == itb_pkg::EDGE_FALL
        && st.pin_s2[0] && !st.pin_d[0] && !st.flag[0] && !wr0 |=> !st.flag[0])
        else $error("falling select flagged a rising edge");
endmodule

// File: test/itb_cpu_model.sv
// behavioural cpu sequencer and return stack facing the controller
module itb_cpu_model #(
    parameter int PC_W = 11,
    parameter int DEPTH = 1,
    parameter logic [PC_W-1:0] START_PC = 'h123
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic run_en,
    input wire logic stack_push,
    input wire logic [PC_W-1:0] stack_push_pc,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_load_addr,
    input wire logic stack_pop,
    output logic cpu_boundary,
    output logic [PC_W-1:0] cpu_next_pc,
    output logic stack_full,
    output logic [PC_W-1:0] pc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [PC_W-1:0] stk [DEPTH];
    int depth;
    // pc never advances, so a restored pc proves the pop
    assign cpu_boundary = run_en;
    assign cpu_next_pc = pc;
    assign stack_full = depth >= DEPTH;
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pc <= START_PC;
            depth <= 0;
        end else if (pc_load && stack_push && depth < DEPTH) begin
            stk[depth] <= stack_push_pc;
            depth <= depth + 1;
            pc <= pc_load_addr;
        end else if (stack_pop && depth > 0) begin
            pc <= stk[depth-1];
            depth <= depth - 1;
        end
    end
endmodule

// File: test/test_mcu_interrupt_and_time_base.sv
// self-checking bench for the interrupt controller and time base
`define CHK(nm, exp, got) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("mismatch %s expected %h seen %h", nm, exp, got); \
    end \
end
module test_mcu_interrupt_and_time_base;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] AE = itb_pkg::IDX_EDGE;
    localparam logic [2:0] A0 = itb_pkg::IDX_CTRL0;
    localparam logic [2:0] A1 = itb_pkg::IDX_CTRL1;
    localparam logic [2:0] AP = itb_pkg::IDX_PSC;
    localparam logic [2:0] AT = itb_pkg::IDX_TICK;
    logic mclk, rstn, ce, sfr_wr, sub_clk, timer_ovf, conv_done, cpu_boundary;
    logic stack_full, reti_exec, ret_exec, irq_pending, irq_take, stack_push;
    logic pc_load, stack_pop, wake, run_en;
    logic [2:0] sfr_addr;
    logic [7:0] sfr_wdata, sfr_rdata, rv;
    logic [1:0] ext_irq_pin;
    logic [10:0] cpu_next_pc, stack_push_pc, pc_load_addr, pc, last_vec;
    int bad_count, tests_run, cyc, n_load, n_wake, t_wake;
    itb_ctrl i_itb_ctrl (.mclk, .rstn, .ce, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
        .ext_irq_pin, .sub_clk, .timer_ovf, .conv_done, .cpu_boundary, .cpu_next_pc,
        .stack_full, .reti_exec, .ret_exec, .irq_pending, .irq_take, .stack_push,
        .stack_push_pc, .pc_load, .pc_load_addr, .stack_pop, .wake);
    itb_cpu_model i_itb_cpu_model (.mclk, .rstn, .run_en, .stack_push, .stack_push_pc,
        .pc_load, .pc_load_addr, .stack_pop, .cpu_boundary, .cpu_next_pc, .stack_full, .pc);
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // sub clock runs free at eight system cycles
    initial begin
        sub_clk = 1'b0;
        forever #20 sub_clk = ~sub_clk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (pc_load) begin
            n_load <= n_load + 1;
            last_vec <= pc_load_addr;
        end
        if (wake) begin
            n_wake <= n_wake + 1;
            t_wake <= cyc;
        end
        if (cyc == 40000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_addr = a;
        sfr_wr = 1'b1;
        sfr_wdata = d;
        @(negedge mclk);
        sfr_wr = 1'b0;
    endtask
    task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
        @(negedge mclk);
        sfr_addr = a;
        @(negedge mclk);
        `CHK("rdata", e, sfr_rdata)
    endtask
    task automatic strobe(input logic [3:0] m);
        @(negedge mclk);
        {ret_exec, conv_done, timer_ovf, reti_exec} = m;
        @(negedge mclk);
        {ret_exec, conv_done, timer_ovf, reti_exec} = 4'h0;
    endtask
    task automatic wait_loads(input int want);
        for (int i = 0; i < 100 && n_load != want; i++) @(negedge mclk);
        `CHK("loads", want, n_load)
    endtask
    task automatic wait_wake(output int t);
        int s;
        s = n_wake;
        for (int i = 0; i < 3000 && n_wake == s; i++) @(negedge mclk);
        t = t_wake;
    endtask
    task automatic t_regs();
        logic [2:0] ix [6] = '{AE, A0, A1, AP, AT, 3'h5};
        logic [7:0] ex [6] = '{8'h0F, 8'h7F, 8'h33, 8'h07, 8'h87, 8'h00};
        for (int i = 0; i < 6; i++) chk_rd(ix[i], 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(ix[i], 8'hFF);
            chk_rd(ix[i], ex[i]);
        end
        for (int i = 0; i < 6; i++) wr(ix[i], 8'h00);
        $display("test regs done");
    endtask
    task automatic t_timer();
        int b;
        b = n_wake;
        run_en = 1'b1;
        wr(A0, 8'h01);
        strobe(4'h2);
        repeat (6) @(negedge mclk);
        `CHK("loads", 0, n_load)
        `CHK("pending", 1'b0, irq_pending)
        `CHK("wakes", b + 1, n_wake)
        chk_rd(A0, 8'h41);
        strobe(4'h2);
        repeat (3) @(negedge mclk);
        `CHK("wakes", b + 1, n_wake)
        wr(A0, 8'h49);
        wait_loads(1);
        `CHK("vector", 11'h00C, last_vec)
        `CHK("pc", 11'h00C, pc)
        chk_rd(A0, 8'h08);
        strobe(4'h1);
        repeat (3) @(negedge mclk);
        `CHK("pc", 11'h123, pc)
        chk_rd(A0, 8'h09);
        $display("test timer done");
    endtask
    task automatic t_prio();
        logic [10:0] v [5] = '{11'h004, 11'h008, 11'h00C, 11'h010, 11'h014};
        wr(A0, 8'h3E);
        wr(A1, 8'h23);
        strobe(4'h6);
        chk_rd(A1, 8'h33);
        chk_rd(A0, 8'h7E);
        wr(A0, 8'h7F);
        for (int k = 0; k < 5; k++) begin
            wait_loads(2 + k);
            `CHK("vector", v[k], last_vec)
            strobe(4'h1);
        end
        chk_rd(A0, 8'h0F);
        chk_rd(A1, 8'h03);
        $display("test priority done");
    endtask
    task automatic t_stack();
        wr(A1, 8'h00);
        wr(A0, 8'h49);
        wait_loads(7);
        wr(A0, 8'h2D);
        repeat (10) @(negedge mclk);
        `CHK("loads", 7, n_load)
        `CHK("pending", 1'b1, irq_pending)
        `CHK("take", 1'b0, irq_take)
        strobe(4'h8);
        wait_loads(8);
        `CHK("vector", 11'h008, last_vec)
        strobe(4'h8);
        repeat (3) @(negedge mclk);
        chk_rd(A0, 8'h0C);
        wr(A0, 8'h00);
        $display("test stack done");
    endtask
    task automatic t_edges();
        for (int m = 0; m < 4; m++) begin
            wr(AE, {4'h0, m[1:0], m[1:0]});
            for (int lv = 0; lv < 2; lv++) begin
                wr(A0, 8'h00);
                wr(A1, 8'h00);
                ext_irq_pin = lv ? 2'b00 : 2'b11;
                repeat (6) @(negedge mclk);
                chk_rd(A0, {3'h0, m[lv], 4'h0});
                chk_rd(A1, {2'h0, m[lv], 5'h0});
            end
        end
        wr(AE, 8'h00);
        $display("test edges done");
    endtask
    task automatic t_tick();
        logic [7:0] ps [7] = '{8'h04, 8'h04, 8'h05, 8'h06, 8'h04, 8'h00, 8'h04};
        logic [7:0] tb [7] = '{8'h80, 8'h81, 8'h80, 8'h80, 8'h87, 8'h80, 8'h00};
        int per [7] = '{16, 32, 64, 128, 2048, 0, 0};
        int t1, t2, b;
        for (int i = 0; i < 7; i++) begin
            wr(AT, 8'h00);
            wr(AP, ps[i]);
            wr(A0, 8'h00);
            wr(AT, tb[i]);
            if (per[i] == 0) begin
                b = n_wake;
                repeat (300) @(negedge mclk);
                `CHK("wakes", b, n_wake)
            end else begin
                wait_wake(t1);
                wr(A0, 8'h00);
                wait_wake(t2);
                `CHK("period", per[i], t2 - t1)
            end
        end
        wr(AT, 8'h00);
        $display("test tick done");
    endtask
    initial begin
        {rstn, sfr_wr, timer_ovf, conv_done, reti_exec, ret_exec, run_en} = 7'h00;
        {sfr_addr, sfr_wdata, ext_irq_pin} = 13'h0000;
        {bad_count, tests_run, cyc, n_load, n_wake, t_wake} = '0;
        ce = 1'b1;
        repeat (2) @(negedge mclk);
        rstn = 1'b1;
        t_regs();
        t_timer();
        t_prio();
        t_stack();
        t_edges();
        t_tick();
        close_out();
    end
endmodule
